//--- cmp_analog_model.sv
`timescale 1ns/1ps
module cmp_analog_model (
   // Commanded input relations.
   input  wire ext_gt_a,
   input  wire ext_gt_b,
   input  wire ref_gt_a,
   input  wire ref_gt_b,
   // Design side.
   input  wire cmp_a_power,
   input  wire cmp_b_power,
   input  wire use_internal_ref,
   output wire cmp_a_raw,
   output wire cmp_b_raw
);
   // An unpowered comparator has no meaningful output, so it wanders.
   reg idle = 1'b0;
   always #37 idle = ~idle;
   // Sleep is not an input: a powered comparator keeps comparing.
   assign cmp_a_raw = cmp_a_power ? (use_internal_ref ? ref_gt_a : ext_gt_a)
                                  : idle;
   assign cmp_b_raw = cmp_b_power ? (use_internal_ref ? ref_gt_b : ext_gt_b)
                                  : ~idle;
endmodule

//--- cmp_control_regs.vh
`ifndef CMP_CONTROL_REGS_VH
`define CMP_CONTROL_REGS_VH

// Register byte offsets on the APB bus.
`define OFS_COMPARATOR_CONTROL 12'h000
`define OFS_IRQ_CONTROL        12'h004
`define OFS_PORT_DIRECTION     12'h008
`define OFS_PORT_DATA          12'h00c

// Comparator control register layout.
`define CC_RESULT_B      7
`define CC_RESULT_A      6
`define CC_INVERT_B      5
`define CC_INVERT_A      4
`define CC_INPUT_SWITCH  3
`define CC_MODE_HI       2
`define CC_MODE_LO       0
`define CC_WRITE_MASK    8'h3f
`define CC_RESET         8'h00

// Interrupt control register layout.
`define IC_FLAG          0
`define IC_ENABLE        1
`define IC_PERIPH_EN     2
`define IC_GLOBAL_EN     3
`define IC_PRIORITY      4
`define IC_RESET         5'h00

// Port direction register: bit 0 for the first output pin, bit 1 for the second.
`define PD_PIN_A         0
`define PD_PIN_B         1
`define PD_RESET         2'h3

// Comparator modes.
`define MODE_RESET       3'h0
`define MODE_OUT_ROUTED  3'h3
`define MODE_OUT_ROUTED2 3'h5
`define MODE_INT_REF     3'h6
`define MODE_OFF         3'h7

// Port pin masks.
`define PORT_CMP_PINS    8'h7e
`define PORT_OUT_PINS    8'h06
`define PORT_NONE        8'h00

`endif

//--- dual_comparator_control.v
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cmp_control_regs.vh"

// How it works
// [R01] Mode 110 steers the internal reference onto both comparators' non-inverting inputs.
// [R02] Both comparator results read at control bits 7:6; writes there are ignored.
// [R03] Routing enabled: two port pins carry the raw comparator results, unsynchronized.
// [R04] Pin direction bits still gate the output enables of the routed pins.
// [R05] Inversion bits 4 and 5 flip each comparator's reported result.
// [R06] Port data reads give zero on every pin currently used as analog input.
// [R07] Any change of either result sets the change flag; no source is kept.
// [R08] Software clears the flag writing zero; writing one raises it as an event.
// [R09] Interrupt request needs all three enables; the flag sets regardless.
// [R10] A change coinciding with a control read may be missed; here set wins.
// [R11] A standing mismatch keeps setting the flag every cycle.
// [R12] Software reads or writes control first, then clears the flag.
// [R13] In sleep an active comparator keeps running and an enabled change wakes.
// [R14] Software should pick mode 111 before sleep to save current.
// [R15] Waking from sleep leaves the control register untouched.
// [R16] Reset forces control to mode 000 and powers both comparators down.
// [R17] Without inversion a result is one when plus input exceeds minus input.
// [R18] Software should mask the interrupt while changing comparator mode.
// [R19] Control layout: results 7:6, inversions 5:4, input switch 3, mode 2:0.
// [R20] Raw results are synchronized before status and change detection use them.
// [R21] Mismatch compares results against a copy latched on each control access.
module dual_comparator_control (
   // APB clock and reset.
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Analog comparator side.
   input  wire        cmp_a_raw,
   input  wire        cmp_b_raw,
   output reg         cmp_a_power,
   output reg         cmp_b_power,
   output reg         use_internal_ref,
   output reg         input_switch_select,
   // Port pins.
   input  wire [7:0]  port_pin_in,
   output reg  [7:0]  analog_pin_mask,
   output wire        cmp_a_out_pin,
   output reg         cmp_a_out_pin_oe,
   output wire        cmp_b_out_pin,
   output reg         cmp_b_out_pin_oe,
   // Interrupt system and power state.
   input  wire        sleep_mode,
   output reg         cmp_irq,
   output reg         cmp_wake
);

   localparam [2:0] st_idle   = 3'b001;
   localparam [2:0] st_access = 3'b010;
   localparam [2:0] st_done   = 3'b100;

   reg [2:0]  bus_state;
   reg [2:0]  next_bus_state;
   reg [7:0]  comparator_control;
   reg [4:0]  irq_control;
   reg [1:0]  port_direction;
   reg [1:0]  sync_a;
   reg [1:0]  sync_b;
   reg [1:0]  latched_results;
   reg [1:0]  pending_set;
   reg [31:0] next_prdata;
   reg        next_pslverr;

   wire [2:0] mode;
   wire       active;
   wire       routed;
   wire [1:0] results;
   wire       mismatch;
   wire       setup;
   wire       finish;
   wire       do_write;
   wire       cc_hit;
   wire       ic_hit;
   wire       pd_hit;
   wire       pdat_hit;
   wire       cc_touch;
   wire       flag_set;

   function comparators_on;
      input [2:0] m;
      begin
         comparators_on = (m != `MODE_RESET) && (m != `MODE_OFF);
      end
   endfunction

   function outputs_routed;
      input [2:0] m;
      begin
         outputs_routed = (m == `MODE_OUT_ROUTED) || (m == `MODE_OUT_ROUTED2);
      end
   endfunction

   function [7:0] analog_mask;
      input [2:0] m;
      begin
         if (m == `MODE_OFF) begin
            analog_mask = `PORT_NONE;
         end else if (outputs_routed(m)) begin
            analog_mask = `PORT_CMP_PINS & ~`PORT_OUT_PINS;
         end else begin
            analog_mask = `PORT_CMP_PINS;
         end
      end
   endfunction

   function addr_is;
      input [11:0] a;
      input [11:0] ofs;
      begin
         addr_is = (a == ofs);
      end
   endfunction

   assign mode     = comparator_control[`CC_MODE_HI:`CC_MODE_LO];
   assign active   = comparators_on(mode);
   assign routed   = outputs_routed(mode);

   // The second synchronizer stage alone feeds status and change detection.
   assign results  = {sync_b[1] ^ comparator_control[`CC_INVERT_B],
                      sync_a[1] ^ comparator_control[`CC_INVERT_A]}; // [R05] [R17] [R20]
   assign mismatch = active && (results != latched_results); // [R21]

   assign setup    = psel && !penable;
   assign finish   = psel && penable && pready;
   assign do_write = finish && pwrite;
   assign cc_hit   = addr_is(paddr, `OFS_COMPARATOR_CONTROL);
   assign ic_hit   = addr_is(paddr, `OFS_IRQ_CONTROL);
   assign pd_hit   = addr_is(paddr, `OFS_PORT_DIRECTION);
   assign pdat_hit = addr_is(paddr, `OFS_PORT_DATA);
   assign cc_touch = finish && cc_hit; // [R12]
   assign flag_set = mismatch || (pending_set != 2'h0); // [R07] [R11]

   // Pins carry the raw comparator outputs, bypassing the synchronizer.
   assign cmp_a_out_pin = routed &
                          (cmp_a_raw ^ comparator_control[`CC_INVERT_A]); // [R03]
   assign cmp_b_out_pin = routed &
                          (cmp_b_raw ^ comparator_control[`CC_INVERT_B]); // [R03]

   // Bus sequencing: no wait cycle; read data is loaded into a flop at the end of the setup cycle.
   always @* begin
      next_bus_state = st_idle;
      case (bus_state)
         st_idle: begin
            if (setup) begin
               next_bus_state = st_access;
            end
         end
         st_access: begin
            next_bus_state = st_done;
         end
         st_done: begin
            if (setup) begin
               next_bus_state = st_access;
            end
         end
         default: begin
            next_bus_state = st_idle;
         end
      endcase
   end

   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (cc_hit) begin
         next_prdata[7:0] = {results[1], results[0],
                             comparator_control[`CC_INVERT_B:`CC_MODE_LO]}; // [R02] [R19]
      end else if (ic_hit) begin
         next_prdata[4:0] = irq_control;
      end else if (pd_hit) begin
         next_prdata[1:0] = port_direction;
      end else if (pdat_hit) begin
         next_prdata[7:0] = port_pin_in & ~analog_pin_mask; // [R06]
      end else begin
         next_pslverr = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= st_idle;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // Ready stands for exactly the one access cycle of each transfer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= (next_bus_state == st_access);
      end
   end

   // Read data and error stand only while ready does, zero otherwise.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (next_bus_state == st_access) begin
         pslverr <= next_pslverr;
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // Registers; no sleep input touches them, so wake leaves them as they were.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comparator_control <= `CC_RESET; // [R16]
      end else if (do_write && cc_hit) begin
         comparator_control <= pwdata[7:0] & `CC_WRITE_MASK; // [R02] [R15]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_direction <= `PD_RESET;
      end else if (do_write && pd_hit) begin
         port_direction <= pwdata[1:0];
      end
   end

   // Set wins over a software clear of the flag.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_control <= `IC_RESET;
      end else begin
         if (do_write && ic_hit) begin
            irq_control <= pwdata[4:0]; // [R08]
         end
         if (flag_set) begin
            irq_control[`IC_FLAG] <= 1'b1; // [R09] [R10] [R11]
         end
      end
   end

   // Raw results are sampled through two stages; off comparators read zero.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 2'h0;
      end else begin
         sync_a <= {sync_a[0], cmp_a_raw & active}; // [R20]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_b <= 2'h0;
      end else begin
         sync_b <= {sync_b[0], cmp_b_raw & active}; // [R20]
      end
   end

   // Copy of the results taken at each control access ends the mismatch.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_results <= 2'h0;
      end else if (cc_touch || !active) begin
         latched_results <= results; // [R21]
      end
   end

   // A change caught in the same cycle as the latch still sets the flag.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_set <= 2'h0;
      end else begin
         pending_set <= (cc_touch && mismatch) ? 2'h1 : 2'h0; // [R07]
      end
   end

   // Analog side controls follow the mode; reset holds both comparators off.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_power <= 1'b0; // [R16]
         cmp_b_power <= 1'b0; // [R16]
      end else begin
         cmp_a_power <= active; // [R13]
         cmp_b_power <= active; // [R13]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         use_internal_ref    <= 1'b0;
         input_switch_select <= 1'b0;
      end else begin
         use_internal_ref    <= (mode == `MODE_INT_REF); // [R01]
         input_switch_select <= (mode == `MODE_INT_REF) &&
                                comparator_control[`CC_INPUT_SWITCH];
      end
   end

   // In reset every comparator pin is an analog input.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_pin_mask <= `PORT_CMP_PINS; // [R16]
      end else begin
         analog_pin_mask <= analog_mask(mode); // [R06]
      end
   end

   // Direction bits keep gating the drivers of the routed pins.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_out_pin_oe <= 1'b0;
         cmp_b_out_pin_oe <= 1'b0;
      end else begin
         cmp_a_out_pin_oe <= routed && !port_direction[`PD_PIN_A]; // [R04]
         cmp_b_out_pin_oe <= routed && !port_direction[`PD_PIN_B]; // [R04]
      end
   end

   // Interrupt request and wake from sleep.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_irq <= 1'b0;
      end else begin
         cmp_irq <= irq_control[`IC_FLAG] && irq_control[`IC_ENABLE] &&
                    irq_control[`IC_PERIPH_EN] && irq_control[`IC_GLOBAL_EN]; // [R09]
      end
   end

   // Wake from sleep needs only the comparator's own enable.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_wake <= 1'b0;
      end else begin
         cmp_wake <= sleep_mode && irq_control[`IC_FLAG] &&
                     irq_control[`IC_ENABLE]; // [R13]
      end
   end

endmodule

//--- dual_comparator_control_assertions.sv
`timescale 1ns/1ps
module cmp_ctrl_chk (
   // Clock and reset.
   input wire        pclk,
   input wire        presetn,
   // APB.
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   // Comparator, pins and interrupt.
   input wire        cmp_a_raw,
   input wire        cmp_a_power,
   input wire        use_internal_ref,
   input wire [7:0]  analog_pin_mask,
   input wire        cmp_a_out_pin,
   input wire        cmp_a_out_pin_oe,
   input wire        sleep_mode,
   input wire        cmp_irq,
   input wire        cmp_wake
);
   // Shadow copies of what software wrote, and cycles since the last write.
   reg  [5:0] cc;
   reg  [1:0] dr;
   reg  [3:0] ic;
   reg  [1:0] age;
   wire       wr = psel & penable & pready & pwrite;
   wire       rt = (cc[2:0] == 3'h3) | (cc[2:0] == 3'h5);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc <= 6'h00;
         dr <= 2'h3;
         ic <= 4'h0;
         age <= 2'h3;
      end else begin
         if (wr && paddr == 12'h000)
            cc <= pwdata[5:0];
         if (wr && paddr == 12'h004)
            ic <= pwdata[3:0];
         if (wr && paddr == 12'h008)
            dr <= pwdata[1:0];
         if (wr)
            age <= 2'h0;
         else if (age != 2'h3)
            age <= age + 2'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_int_ref: assert property (age == 2'h3 |-> use_internal_ref == (cc[2:0] == 3'h6))
      else $error("internal reference select wrong");
   a_ctrl_layout: assert property (pready && !pwrite && paddr == 12'h000
      |-> prdata[31:8] == 24'h0 && prdata[5:0] == cc) else $error("control read wrong");
   a_pin_direct: assert property (age == 2'h3
      |-> cmp_a_out_pin == (rt & (cmp_a_raw ^ cc[4]))) else $error("routed pin wrong");
   a_pin_enable: assert property (age == 2'h3 |-> cmp_a_out_pin_oe == (rt & !dr[0]))
      else $error("pin enable wrong");
   a_port_zero: assert property (pready && !pwrite && paddr == 12'h00c
      |-> (prdata[7:0] & analog_pin_mask) == 8'h00) else $error("analog pin read not zero");
   a_irq_gate: assert property (age == 2'h3 && cmp_irq |-> &ic[3:1])
      else $error("irq without enables");
   a_wake_sleep: assert property (age == 2'h3 && cmp_wake |-> $past(sleep_mode) && ic[1])
      else $error("wake without sleep");
   a_mode_power: assert property (age == 2'h3
      |-> cmp_a_power == (cc[2:0] != 3'h0 && cc[2:0] != 3'h7)) else $error("power wrong");
endmodule

bind dual_comparator_control cmp_ctrl_chk u_cmp_ctrl_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .cmp_a_raw(cmp_a_raw), .cmp_a_power(cmp_a_power),
   .use_internal_ref(use_internal_ref), .analog_pin_mask(analog_pin_mask),
   .cmp_a_out_pin(cmp_a_out_pin), .cmp_a_out_pin_oe(cmp_a_out_pin_oe),
   .sleep_mode(sleep_mode), .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));

//--- dual_comparator_control_tb.sv
`timescale 1ns/1ps
module dual_comparator_control_tb;
   logic        pclk = 1'b0, presetn = 1'b0, sleep_mode = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic [7:0]  pin_in = 8'hff, amask;
   logic        pready, pslverr, rerr, a_raw, b_raw, a_pw, b_pw, iref, isw;
   logic        a_pin, a_oe, b_pin, b_oe, cmp_irq, cmp_wake;
   logic        ext_a = 1'b0, ext_b = 1'b0, ref_a = 1'b0, ref_b = 1'b0;
   logic [7:0]  exp_pins [8] = '{8'h81, 8'h81, 8'h81, 8'h87, 8'h81, 8'h87, 8'h81, 8'hff};
   int          err_count = 0, num_checks = 0, m;
   always #50 pclk = ~pclk;
   dual_comparator_control u_dual_comparator_control (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_a_raw(a_raw),
      .cmp_b_raw(b_raw), .cmp_a_power(a_pw), .cmp_b_power(b_pw), .use_internal_ref(iref),
      .input_switch_select(isw), .port_pin_in(pin_in), .analog_pin_mask(amask),
      .cmp_a_out_pin(a_pin), .cmp_a_out_pin_oe(a_oe), .cmp_b_out_pin(b_pin),
      .cmp_b_out_pin_oe(b_oe), .sleep_mode(sleep_mode), .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));
   cmp_analog_model u_cmp_analog_model (.ext_gt_a(ext_a), .ext_gt_b(ext_b), .ref_gt_a(ref_a),
      .ref_gt_b(ref_b), .cmp_a_power(a_pw), .cmp_b_power(b_pw), .use_internal_ref(iref),
      .cmp_a_raw(a_raw), .cmp_b_raw(b_raw));
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reads leave time for the input synchronizer to settle first.
   task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
      repeat (3) @(posedge pclk);
      apb(1'b0, a, 32'h0);
      check(name, rdv, exp);
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h00, "ctrl reset");
      rd(12'h004, 32'h00, "irq reset");
      rd(12'h008, 32'h03, "dir reset");
      rd(12'h010, 32'h00, "unmapped");
      check("slverr", {31'h0, rerr}, 32'h1);
      apb(1'b1, 12'h000, 32'hcf);
      rd(12'h000, 32'h0f, "ctrl ro bits");
      $display("test reset done");
      for (m = 0; m < 8; m++) begin
         apb(1'b1, 12'h000, 32'(m));
         rd(12'h00c, {24'h0, exp_pins[m]}, "port data");
         check("power", {31'h0, a_pw & b_pw}, {31'h0, m != 0 && m != 7});
         check("int ref", {31'h0, iref}, {31'h0, m == 6});
      end
      $display("test modes done");
      ext_a <= 1'b1;
      apb(1'b1, 12'h000, 32'h02);
      rd(12'h000, 32'h42, "result");
      apb(1'b1, 12'h000, 32'h32);
      rd(12'h000, 32'hb2, "inverted");
      ref_b <= 1'b1;
      apb(1'b1, 12'h000, 32'h0e);
      rd(12'h000, 32'h8e, "internal ref");
      check("in switch", {31'h0, isw}, 32'h1);
      $display("test results done");
      apb(1'b1, 12'h004, 32'h0);
      rd(12'h004, 32'h0, "flag clear");
      ref_a <= 1'b1;
      rd(12'h004, 32'h1, "flag set");
      apb(1'b1, 12'h004, 32'h0);
      rd(12'h004, 32'h1, "flag held");
      rd(12'h000, 32'hce, "ctrl read");
      apb(1'b1, 12'h004, 32'h0);
      rd(12'h004, 32'h0, "flag cleared");
      apb(1'b1, 12'h004, 32'h1);
      rd(12'h004, 32'h1, "flag sw set");
      apb(1'b1, 12'h004, 32'h0b);
      rd(12'h004, 32'h0b, "enables");
      check("irq masked", {31'h0, cmp_irq}, 32'h0);
      apb(1'b1, 12'h004, 32'h0f);
      repeat (3) @(posedge pclk);
      check("irq", {31'h0, cmp_irq}, 32'h1);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      check("wake", {31'h0, cmp_wake}, 32'h1);
      sleep_mode <= 1'b0;
      rd(12'h000, 32'hce, "after wake");
      $display("test flag done");
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h2);
      apb(1'b1, 12'h000, 32'h23);
      repeat (3) @(posedge pclk);
      check("pin a", {31'h0, a_pin}, 32'h1);
      check("pin b", {31'h0, b_pin}, 32'h1);
      check("oe", {30'h0, b_oe, a_oe}, 32'h1);
      ext_a <= 1'b0;
      #10;
      check("pin a fast", {31'h0, a_pin}, 32'h0);
      $display("test routing done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("reset power", {30'h0, a_pw, b_pw}, 32'h0);
      check("reset pins", {30'h0, a_pin, b_pin}, 32'h0);
      presetn <= 1'b1;
      rd(12'h000, 32'h00, "ctrl rereset");
      rd(12'h004, 32'h00, "irq rereset");
      apb(1'b1, 12'h000, 32'h07);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      check("sleep off", {30'h0, a_pw | b_pw, cmp_wake}, 32'h0);
      sleep_mode <= 1'b0;
      $display("test reset and sleep done");
      end_of_test;
   end
   initial begin
      #300000;
      err_count++;
      end_of_test;
   end
endmodule
